// file: rtl/fault_sim_cfg.svh
// offsets, field positions, reset values and timing counts of the sequencer
`ifndef FAULT_SIM_CFG_SVH
`define FAULT_SIM_CFG_SVH
`define CLK_HZ          25000000
`define RESET_PHASE_MS  100
`define RESET_PHASE_CYC ((`CLK_HZ / 1000) * `RESET_PHASE_MS)
`define REARM_S         5
`define REARM_CYC       (`CLK_HZ * `REARM_S)
// phase currents in per-mille of nominal; 0.1 x nominal is 100
`define OC_LIMIT_PM     16'h0064
// simulation frequency is 0.16 % above rated: factor 10016 / 10000
`define FREQ_NUM        32'h00002720
`define FREQ_DEN        32'h00002710
// register byte offsets
`define A_CTRL          12'h000
`define A_STATUS        12'h004
`define A_PRE_T         12'h008
`define A_FLT_T         12'h00c
`define A_POST_T        12'h010
`define A_RATED_F       12'h014
`define A_SIM_F         12'h018
`define A_VQ_BASE       12'h040
`define A_IQ_BASE       12'h060
// ctrl fields
`define C_START         0
`define C_STOP          1
`define C_HOT           2
`define C_FPOST_EN      3
`define C_XSTART_EN     4
`define C_BLKA_EN       5
`define C_BLKB_EN       6
// reset values
`define PRE_T_RST       32'h00000000
`define RATED_F_RST     32'h00000000
`endif

// file: rtl/fault_sim_pkg.sv
// types of the fault simulation sequencer
package fault_sim_pkg;
    typedef enum logic [2:0] {
        ST_NORMAL, ST_PRE, ST_FAULT, ST_POST, ST_RESET_IN, ST_RESET_OUT
    } seq_state_e;
    typedef logic [31:0] word_t;
endpackage : fault_sim_pkg

// file: rtl/fault_simulation_sequencer.sv
// fault simulation sequencer with apb register file
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`include "fault_sim_cfg.svh"

module fault_simulation_sequencer #(
    parameter int          NCH       = 4,
    parameter int unsigned REARM_CYC = `REARM_CYC,
    parameter int unsigned RESET_CYC = `RESET_PHASE_CYC
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              external_block_a,
    input  wire logic              external_block_b,
    input  wire logic              external_jump_to_postfault,
    input  wire logic              external_sim_start,
    input  wire logic [NCH*16-1:0] phase_current_pm,
    input  wire logic [NCH*16-1:0] meas_voltage,
    input  wire logic [NCH*16-1:0] meas_current,
    input  wire logic              trip_command,
    output logic      [NCH*16-1:0] prot_voltage,
    output logic      [NCH*16-1:0] prot_current,
    output logic                   prot_reinit,
    output logic                   trip_out,
    output logic                   energy_hold,
    output logic      [2:0]        phase_code,
    output logic      [31:0]       sim_freq
);

    // pin synchronisers, stage one read by stage two only
    logic [3:0] pin_s1_reg;
    logic [3:0] pin_s2_reg;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_s1_reg <= 4'h0;
            pin_s2_reg <= 4'h0;
        end
        else
        begin
            pin_s1_reg <= {external_sim_start, external_jump_to_postfault,
                           external_block_b, external_block_a};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // registers
    logic [6:0]                ctrl_reg;
    fault_sim_pkg::word_t      pre_t_reg;
    fault_sim_pkg::word_t      flt_t_reg;
    fault_sim_pkg::word_t      post_t_reg;
    fault_sim_pkg::word_t      rated_f_reg;
    logic [15:0]               vq_reg [3][NCH];
    logic [15:0]               iq_reg [3][NCH];
    fault_sim_pkg::seq_state_e state_reg;
    logic [31:0]               cnt_reg;
    logic [31:0]               rearm_reg;
    logic                      abort_reg;

    wire wr = psel && penable && pwrite;
    wire rd_ok_start = wr && paddr == `A_CTRL && pwdata[`C_START];
    wire stop_cmd    = wr && paddr == `A_CTRL && pwdata[`C_STOP];

    // decodes a quantity slot: phase index 0..2, channel index
    function automatic logic slot_hit(input logic [11:0] a,
                                      input logic [11:0] base,
                                      input int ph, input int ch);
        slot_hit = a == base + 12'((ph * NCH + ch) * 4);
    endfunction : slot_hit

    // overcurrent on any real phase channel
    logic oc;
    always_comb
    begin
        oc = 1'b0;
        for (int c = 0; c < NCH; c++)
            if (phase_current_pm[c*16 +: 16] > `OC_LIMIT_PM)
                oc = 1'b1;
    end

    wire blocked = (ctrl_reg[`C_BLKA_EN] && pin_s2_reg[0]) ||
                   (ctrl_reg[`C_BLKB_EN] && pin_s2_reg[1]);
    wire inhibit = oc || abort_reg || blocked;
    wire xstart  = ctrl_reg[`C_XSTART_EN] && pin_s2_reg[3];
    wire fpost   = ctrl_reg[`C_FPOST_EN] && pin_s2_reg[2];
    // stop wins over a start carried in the same write
    wire go      = (rd_ok_start || xstart) && !stop_cmd && !inhibit;

    // control register and per-phase settings
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg    <= 7'h00;
            pre_t_reg   <= `PRE_T_RST;
            flt_t_reg   <= `PRE_T_RST;
            post_t_reg  <= `PRE_T_RST;
            rated_f_reg <= `RATED_F_RST;
            for (int p = 0; p < 3; p++)
                for (int c = 0; c < NCH; c++)
                begin
                    vq_reg[p][c] <= 16'h0000;
                    iq_reg[p][c] <= 16'h0000;
                end
        end
        else if (wr)
        begin
            // start and stop are strobes, never stored
            if (paddr == `A_CTRL)
                ctrl_reg <= {pwdata[6:2], 2'b00};
            if (paddr == `A_PRE_T)
                pre_t_reg <= pwdata;
            if (paddr == `A_FLT_T)
                flt_t_reg <= pwdata;
            if (paddr == `A_POST_T)
                post_t_reg <= pwdata;
            if (paddr == `A_RATED_F)
                rated_f_reg <= pwdata;
            for (int p = 0; p < 3; p++)
                for (int c = 0; c < NCH; c++)
                begin
                    // voltages held as phase-to-neutral values
                    if (slot_hit(paddr, `A_VQ_BASE, p, c))
                        vq_reg[p][c] <= pwdata[15:0];
                    if (slot_hit(paddr, `A_IQ_BASE, p, c))
                        iq_reg[p][c] <= pwdata[15:0];
                end
        end
    end

    // overcurrent abort latch with five second rearm
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            abort_reg <= 1'b0;
            rearm_reg <= 32'h0;
        end
        else if (oc)
        begin
            rearm_reg <= 32'h0;
            if (state_reg != fault_sim_pkg::ST_NORMAL)
                abort_reg <= 1'b1;
        end
        else if (abort_reg)
        begin
            // low current must stand unbroken for the full interval
            if (rearm_reg >= REARM_CYC - 1)
                abort_reg <= 1'b0;
            rearm_reg <= rearm_reg + 32'h1;
        end
    end

    // sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= fault_sim_pkg::ST_NORMAL;
            cnt_reg   <= 32'h0;
        end
        else if (state_reg != fault_sim_pkg::ST_NORMAL && (oc || stop_cmd))
        begin
            // abort skips the closing reset phase: stop acts at once
            state_reg <= fault_sim_pkg::ST_NORMAL;
            cnt_reg   <= 32'h0;
        end
        else
        begin
            cnt_reg <= cnt_reg + 32'h1;
            case (state_reg)
                fault_sim_pkg::ST_NORMAL:
                begin
                    cnt_reg <= 32'h0;
                    if (go)
                        state_reg <= fault_sim_pkg::ST_RESET_IN;
                end
                fault_sim_pkg::ST_RESET_IN:
                    if (cnt_reg >= RESET_CYC - 1)
                    begin
                        state_reg <= fault_sim_pkg::ST_PRE;
                        cnt_reg   <= 32'h0;
                    end
                fault_sim_pkg::ST_PRE:
                    if (fpost)
                    begin
                        state_reg <= fault_sim_pkg::ST_POST;
                        cnt_reg   <= 32'h0;
                    end
                    else if (cnt_reg + 32'h1 >= pre_t_reg)
                    begin
                        state_reg <= fault_sim_pkg::ST_FAULT;
                        cnt_reg   <= 32'h0;
                    end
                fault_sim_pkg::ST_FAULT:
                    if (fpost || cnt_reg + 32'h1 >= flt_t_reg)
                    begin
                        state_reg <= fault_sim_pkg::ST_POST;
                        cnt_reg   <= 32'h0;
                    end
                fault_sim_pkg::ST_POST:
                    if (cnt_reg + 32'h1 >= post_t_reg)
                    begin
                        state_reg <= fault_sim_pkg::ST_RESET_OUT;
                        cnt_reg   <= 32'h0;
                    end
                fault_sim_pkg::ST_RESET_OUT:
                    if (cnt_reg >= RESET_CYC - 1)
                    begin
                        state_reg <= fault_sim_pkg::ST_NORMAL;
                        cnt_reg   <= 32'h0;
                    end
                default:
                    state_reg <= fault_sim_pkg::ST_NORMAL;
            endcase
        end
    end

    // phase code and quantity select of the present state
    logic [2:0] code_next;
    logic [1:0] qsel;
    always_comb
    begin
        qsel = 2'd0;
        case (state_reg)
            fault_sim_pkg::ST_NORMAL:    code_next = 3'h0;
            fault_sim_pkg::ST_PRE:       code_next = 3'h1;
            fault_sim_pkg::ST_FAULT:
            begin
                code_next = 3'h2;
                qsel      = 2'd1;
            end
            fault_sim_pkg::ST_POST:
            begin
                code_next = 3'h3;
                qsel      = 2'd2;
            end
            default:                     code_next = 3'h4;
        endcase
    end

    // outputs, all registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_code   <= 3'h0;
            prot_reinit  <= 1'b0;
            trip_out     <= 1'b0;
            energy_hold  <= 1'b0;
            prot_voltage <= '0;
            prot_current <= '0;
            sim_freq     <= 32'h0;
        end
        else
        begin
            phase_code  <= code_next;
            prot_reinit <= code_next == 3'h4;
            energy_hold <= code_next != 3'h0;
            // cold mode keeps trips internal outside ST_NORMAL, hot lets them out
            trip_out    <= trip_command &&
                           (code_next == 3'h0 ||
                            ctrl_reg[`C_HOT]);
            sim_freq    <= 32'((64'(rated_f_reg) * `FREQ_NUM) /
                               `FREQ_DEN);
            for (int c = 0; c < NCH; c++)
            begin
                prot_voltage[c*16 +: 16] <= code_next == 3'h0 ?
                    meas_voltage[c*16 +: 16] : vq_reg[qsel][c];
                prot_current[c*16 +: 16] <= code_next == 3'h0 ?
                    meas_current[c*16 +: 16] : iq_reg[qsel][c];
            end
        end
    end

    // apb read path, zero wait states
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (psel && !penable && !pwrite)
        begin
            prdata <= 32'h0;
            case (paddr)
                `A_CTRL:    prdata <= {25'h0, ctrl_reg};
                `A_STATUS:  prdata <= {24'h0, blocked, oc, abort_reg,
                                       2'b00, code_next};
                `A_PRE_T:   prdata <= pre_t_reg;
                `A_FLT_T:   prdata <= flt_t_reg;
                `A_POST_T:  prdata <= post_t_reg;
                `A_RATED_F: prdata <= rated_f_reg;
                `A_SIM_F:   prdata <= sim_freq;
                default:
                    for (int p = 0; p < 3; p++)
                        for (int c = 0; c < NCH; c++)
                        begin
                            if (slot_hit(paddr, `A_VQ_BASE, p, c))
                                prdata <= {16'h0, vq_reg[p][c]};
                            if (slot_hit(paddr, `A_IQ_BASE, p, c))
                                prdata <= {16'h0, iq_reg[p][c]};
                        end
            endcase
        end
    end

    // pready low in reset and high from the first clock after it, no errors: unmapped reads zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= 1'b1;
            pslverr <= 1'b0;
        end
    end

    a_cold_trip_gate: assert property (@(posedge pclk) disable iff (!presetn)
        phase_code != 3'h0 && !ctrl_reg[`C_HOT] |-> !trip_out)
        else $error("trip left device in cold mode");
    a_oc_abort: assert property (@(posedge pclk) disable iff (!presetn)
        oc && state_reg != fault_sim_pkg::ST_NORMAL |=> 
        state_reg == fault_sim_pkg::ST_NORMAL)
        else $error("overcurrent did not abort");
    a_stop_ends: assert property (@(posedge pclk) disable iff (!presetn)
        stop_cmd |=> state_reg == fault_sim_pkg::ST_NORMAL)
        else $error("stop did not end run");
    a_force_post: assert property (@(posedge pclk) disable iff (!presetn)
        fpost && !oc && !stop_cmd && (state_reg == fault_sim_pkg::ST_PRE ||
        state_reg == fault_sim_pkg::ST_FAULT) |=>
        state_reg == fault_sim_pkg::ST_POST)
        else $error("force-post ignored");
    a_pre_after_reset: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(state_reg) && state_reg == fault_sim_pkg::ST_PRE |->
        $past(state_reg) == fault_sim_pkg::ST_RESET_IN)
        else $error("pre-fault without reset phase");
    a_block_start: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == fault_sim_pkg::ST_NORMAL && blocked |=>
        state_reg == fault_sim_pkg::ST_NORMAL)
        else $error("blocked start taken");
    a_energy_hold: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 energy_hold == ($past(state_reg) != fault_sim_pkg::ST_NORMAL))
        else $error("energy hold wrong");
    a_phase_code: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == fault_sim_pkg::ST_FAULT && $stable(state_reg) |=>
        phase_code == 3'h2)
        else $error("fault code wrong");
    a_rearm_hold: assert property (@(posedge pclk) disable iff (!presetn)
        abort_reg && state_reg == fault_sim_pkg::ST_NORMAL |=>
        state_reg == fault_sim_pkg::ST_NORMAL)
        else $error("start during rearm");

endmodule : fault_simulation_sequencer

// file: bench/prot_partner.sv
// behavioural protection function standing behind the sequencer
module prot_partner #(
    parameter logic [15:0] PICKUP = 16'h0400
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [15:0] current_ch0,
    input  wire logic        reinit,
    input  wire logic [3:0]  trip_delay,
    output logic             trip_command
);
    logic [3:0] cnt_reg;

    // pick-up timer; reinit puts the function back in a healthy state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_reg <= 4'h0;
        else if (reinit || current_ch0 <= PICKUP)
            cnt_reg <= 4'h0;
        else if (cnt_reg != trip_delay)
            cnt_reg <= cnt_reg + 4'h1;
    end

    // trips only when the delay has run, so slow functions can be modelled
    assign trip_command = (current_ch0 > PICKUP) && !reinit
                          && (cnt_reg == trip_delay);
endmodule : prot_partner

// file: bench/fault_simulation_sequencer_test.sv
// self-checking bench of the fault simulation sequencer
module fault_simulation_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [11:0] wa;
        logic [31:0] wd;
        logic [11:0] ra;
        logic [31:0] rexp;
    } row_s;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        blk_a, blk_b, ext_start, trip_command, prot_reinit;
    logic        trip_out, energy_hold, mon_on, cold, trip_seen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, sim_freq, rd_q;
    logic [63:0] phase_current_pm, meas_voltage, meas_current;
    logic [63:0] prot_voltage, prot_current;
    logic [2:0]  phase_code, last_code;
    logic [3:0]  trip_delay;
    logic [2:0]  seq_q[$];
    int          len_q[$];
    int          miscompares, cmp_count, run_len;
    row_s        rows[9];

    fault_simulation_sequencer #(.REARM_CYC(50), .RESET_CYC(8))
        fault_simulation_sequencer_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .external_block_a(blk_a),
        .external_block_b(blk_b),
        .external_jump_to_postfault(trip_command),
        .external_sim_start(ext_start), .phase_current_pm(phase_current_pm),
        .meas_voltage(meas_voltage), .meas_current(meas_current),
        .trip_command(trip_command), .prot_voltage(prot_voltage),
        .prot_current(prot_current), .prot_reinit(prot_reinit),
        .trip_out(trip_out), .energy_hold(energy_hold),
        .phase_code(phase_code), .sim_freq(sim_freq));

    prot_partner prot_partner_inst (
        .pclk(pclk), .presetn(presetn), .current_ch0(prot_current[15:0]),
        .reinit(prot_reinit), .trip_delay(trip_delay),
        .trip_command(trip_command));

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic end_test(input string nm);
        $display("test %s done, mismatches so far %0d", nm, miscompares);
    endtask : end_test

    // one transfer, entered just after a rising edge; idle cycle after it
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            chk("pready", 32'h1, 32'h0);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr

    task automatic wait_code(input logic [2:0] c, input int lim);
        int n;
        n = 0;
        while (phase_code !== c && n < lim)
        begin
            @(posedge pclk);
            n++;
        end
        chk("phase_code", {29'h0, c}, {29'h0, phase_code});
    endtask : wait_code

    task automatic stay_code(input int n);
        repeat (n)
        begin
            @(posedge pclk);
            chk("phase_code_idle", 32'h0, {29'h0, phase_code});
        end
    endtask : stay_code

    // queues are cleared off the edge the monitor samples on
    task automatic clr;
        @(negedge pclk);
        seq_q.delete();
        len_q.delete();
        trip_seen = 1'b0;
        @(posedge pclk);
    endtask : clr

    task automatic chk_run(input bit full);
        logic [2:0] es[6];
        int         el[6];
        es = '{3'h4, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
        el = '{0, 8, 5, 6, 4, 8};
        chk("run_steps", 32'd6, 32'(seq_q.size()));
        for (int i = 0; i < 6 && i < seq_q.size(); i++)
        begin
            chk("run_code", {29'h0, es[i]}, {29'h0, seq_q[i]});
            if (full && i > 0)
                chk("run_len", 32'(el[i]), 32'(len_q[i]));
        end
    endtask : chk_run

    // code log and per-cycle output relations; post set was left at zero
    always @(posedge pclk)
    begin
        if (mon_on && presetn)
        begin
            if (phase_code !== last_code)
            begin
                seq_q.push_back(phase_code);
                len_q.push_back(run_len);
                run_len = 1;
            end
            else
                run_len++;
            last_code = phase_code;
            if (trip_out === 1'b1)
                trip_seen = 1'b1;
            chk("energy_hold", {31'h0, phase_code != 3'h0},
                {31'h0, energy_hold});
            chk("prot_reinit", {31'h0, phase_code == 3'h4},
                {31'h0, prot_reinit});
            chk("prot_voltage", (phase_code == 3'h2) ? 32'h0222 :
                (phase_code == 3'h3) ? 32'h0 :
                (phase_code == 3'h0) ? {16'h0, meas_voltage[15:0]} :
                32'h0111, {16'h0, prot_voltage[15:0]});
            if (cold)
                chk("trip_out_cold", 32'h0, {31'h0, trip_out});
        end
    end

    initial
    begin
        repeat (5000) @(posedge pclk);
        $display("MISMATCH watchdog expected end seen hang");
        miscompares++;
        report_and_stop();
    end

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        blk_a = 1'b0;
        blk_b = 1'b0;
        ext_start = 1'b0;
        phase_current_pm = 64'h0;
        meas_voltage = 64'h0004_0003_0002_0abc;
        meas_current = 64'h0;
        trip_delay = 4'h2;
        mon_on = 1'b0;
        cold = 1'b1;
        trip_seen = 1'b0;
        last_code = 3'h0;
        run_len = 0;
        miscompares = 0;
        cmp_count = 0;
        rows = '{'{12'h008, 32'h5, 12'h008, 32'h5},
                 '{12'h00c, 32'h6, 12'h00c, 32'h6},
                 '{12'h010, 32'h4, 12'h010, 32'h4},
                 '{12'h014, 32'h2710, 12'h018, 32'h2720},
                 '{12'h040, 32'h0111, 12'h040, 32'h0111},
                 '{12'h050, 32'h0222, 12'h050, 32'h0222},
                 '{12'h070, 32'h0500, 12'h070, 32'h0500},
                 '{12'hffc, 32'h1234, 12'hffc, 32'h0},
                 '{12'h018, 32'h9999, 12'h018, 32'h2720}};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("reset_code", 32'h0, {29'h0, phase_code});
        chk("reset_hold", 32'h0, {31'h0, energy_hold});
        chk("reset_slverr", 32'h0, {31'h0, pslverr});
        mon_on <= 1'b1;
        end_test("reset");
        foreach (rows[i])
        begin
            wr(rows[i].wa, rows[i].wd);
            apb(1'b0, rows[i].ra, 32'h0, rd_q);
            chk("reg_read", rows[i].rexp, rd_q);
        end
        chk("sim_freq", 32'h2720, sim_freq);
        end_test("registers");
        // cold run, no force-post: every phase to its end
        clr();
        wr(12'h000, 32'h1);
        repeat (45) @(posedge pclk);
        chk_run(1'b1);
        wr(12'h000, 32'h3);
        stay_code(12);
        end_test("cold_run");
        // hot run, trip forces post-fault; slow partner
        cold <= 1'b0;
        trip_delay <= 4'h5;
        wr(12'h00c, 32'd40);
        clr();
        wr(12'h000, 32'h0d);
        repeat (60) @(posedge pclk);
        chk_run(1'b0);
        chk("fault_cut", 32'h1, 32'(len_q.size() > 3 && len_q[3] < 40));
        chk("trip_passed", 32'h1, {31'h0, trip_seen});
        end_test("hot_force_post");
        // manual stop in fault goes straight to normal
        cold <= 1'b1;
        clr();
        wr(12'h000, 32'h1);
        wait_code(3'h2, 30);
        wr(12'h000, 32'h2);
        wait_code(3'h0, 4);
        @(posedge pclk);
        chk("stop_from", 32'h2, 32'(seq_q[seq_q.size() - 2]));
        end_test("manual_stop");
        // overcurrent abort, refusal and rearm
        wr(12'h000, 32'h1);
        wait_code(3'h1, 20);
        phase_current_pm[15:0] <= 16'h0065;
        wait_code(3'h0, 3);
        wr(12'h000, 32'h1);
        stay_code(8);
        phase_current_pm[15:0] <= 16'h0000;
        wr(12'h000, 32'h1);
        stay_code(8);
        repeat (50) @(posedge pclk);
        phase_current_pm[15:0] <= 16'h0064;
        wr(12'h000, 32'h1);
        wait_code(3'h4, 6);
        wr(12'h000, 32'h2);
        wait_code(3'h0, 4);
        end_test("overcurrent");
        // external start held off by either block input
        wr(12'h000, 32'h70);
        blk_a <= 1'b1;
        ext_start <= 1'b1;
        stay_code(10);
        blk_a <= 1'b0;
        blk_b <= 1'b1;
        stay_code(10);
        blk_b <= 1'b0;
        wait_code(3'h4, 8);
        ext_start <= 1'b0;
        presetn <= 1'b0;
        @(posedge pclk);
        chk("midrun_reset", 32'h0, {29'h0, phase_code});
        presetn <= 1'b1;
        @(posedge pclk);
        end_test("external_block");
        report_and_stop();
    end
endmodule : fault_simulation_sequencer_test
